//--- dual_timer_counter_extint.sv
`timescale 1ns/1ps
// What this block does
// - Timer one overflow sets its flag; entering its service routine clears it.
// - Timer zero overflow sets its flag; entering its service routine clears it.
// - Each timer has a run bit: 1 counts, 0 halts.
// - Falling edge on each interrupt pin sets an edge flag; vectoring clears it.
// - Trigger-type bit: 0 low level, 1 falling edge.
// - Gate 0 counts on run; gate 1 also needs interrupt pin high.
// - Source select 0 counts every two clocks; 1 counts count-pin falling edges.
// - Mode 00: 8-bit high byte counter behind a 5-bit low byte prescaler.
// - Mode 01: full 16-bit counter over both bytes.
// - Mode 10: low byte counts, reloaded from high byte on overflow.
// - Timer one in mode 11 stops and holds its value.
// - Timer zero mode 11: two 8-bit counters, high uses timer one run/flag.
// - All four count bytes are read/write and reset to zero.
module dual_timer_counter_extint
  import timer_pkg::*;
(
  input  wire logic       clk,
  input  wire logic       nrst,
  input  wire logic [7:0] reg_addr,
  input  wire logic       reg_write,
  input  wire logic [7:0] reg_wdata,
  input  wire logic       reg_read,
  output logic      [7:0] reg_rdata,
  input  wire logic       ack_timer_zero,
  input  wire logic       ack_timer_one,
  input  wire logic       ack_ext_zero,
  input  wire logic       ack_ext_one,
  input  wire logic       ext_irq_zero_pin,
  input  wire logic       ext_irq_one_pin,
  input  wire logic       count_input_zero_pin,
  input  wire logic       count_input_one_pin,
  output logic            ext_irq_zero_request,
  output logic            ext_irq_one_request
);

  logic [7:0] timer_irq_control;
  logic [7:0] timer_mode_config;
  logic [7:0] timer_zero_count_low;
  logic [7:0] timer_zero_count_high;
  logic [7:0] timer_one_count_low;
  logic [7:0] timer_one_count_high;
  logic [3:0] sync_a;
  logic [3:0] sync_b;
  logic [3:0] sync_prev;
  logic       half_rate;

  // Pins idle high; starting the pipeline there avoids a request or gate blip after reset
  localparam logic [3:0] PIN_IDLE = 4'hF;

  always_ff @(posedge clk) begin
    if (!nrst) begin
      sync_a    <= PIN_IDLE;
      sync_b    <= PIN_IDLE;
      sync_prev <= PIN_IDLE;
    end else begin
      sync_a    <= {count_input_one_pin, count_input_zero_pin, ext_irq_one_pin, ext_irq_zero_pin};
      sync_b    <= sync_a;
      sync_prev <= sync_b;
    end
  end

  wire       ext_irq_zero_pin_level = sync_b[0];
  wire       ext_irq_one_pin_level = sync_b[1];
  wire [3:0] fall       = sync_prev & ~sync_b;

  always_ff @(posedge clk) begin
    if (!nrst) half_rate <= 1'b0;
    else       half_rate <= ~half_rate;
  end

  wire t0_run    = timer_irq_control[BIT_T0_RUN];
  wire t1_run    = timer_irq_control[BIT_T1_RUN];
  wire t0_gate   = timer_mode_config[BIT_T0_GATE];
  wire t1_gate   = timer_mode_config[BIT_T1_GATE];
  wire t0_src    = timer_mode_config[BIT_T0_SRC];
  wire t1_src    = timer_mode_config[BIT_T1_SRC];
  wire [1:0] t0_mode = timer_mode_config[BIT_T0_MODE +: 2];
  wire [1:0] t1_mode = timer_mode_config[BIT_T1_MODE +: 2];

  wire t0_enable = t0_run & (~t0_gate | ext_irq_zero_pin_level);
  wire t1_enable = t1_run & (~t1_gate | ext_irq_one_pin_level);
  wire t0_tick   = t0_enable & (t0_src ? fall[2] : half_rate);
  wire t1_tick   = t1_enable & (t1_src ? fall[3] : half_rate);
  // Split high byte runs off the system clock under timer one's run bit
  wire th0_tick  = t1_run & half_rate;
  wire t1_active = t1_tick & (t1_mode != MODE_SPLIT);

  typedef struct packed {
    logic [7:0] low;
    logic [7:0] high;
    logic       ovf;
  } step_t;

  function automatic step_t advance(input logic [1:0] mode, input logic [7:0] lo,
                                    input logic [7:0] hi);
    step_t r;
    r = '{low: lo, high: hi, ovf: 1'b0};
    case (mode)
      MODE_PRESCALED: begin
        r.low = (lo & ~PRESCALE_MASK) | ((lo + 8'h01) & PRESCALE_MASK);
        if ((lo & PRESCALE_MASK) == PRESCALE_TOP) begin
          r.high = hi + 8'h01;
          r.ovf  = (hi == BYTE_TOP);
        end
      end
      MODE_FULL: begin
        {r.high, r.low} = {hi, lo} + 16'h0001;
        r.ovf = ({hi, lo} == {BYTE_TOP, BYTE_TOP});
      end
      MODE_RELOAD: begin
        r.low = (lo == BYTE_TOP) ? hi : lo + 8'h01;
        r.ovf = (lo == BYTE_TOP);
      end
      default: begin
        r.low = lo + 8'h01;
        r.ovf = (lo == BYTE_TOP);
      end
    endcase
    return r;
  endfunction

  wire step_t t0_step = advance(t0_mode, timer_zero_count_low, timer_zero_count_high);
  wire step_t t1_step = advance(t1_mode, timer_one_count_low, timer_one_count_high);
  wire        th0_ovf = th0_tick & (timer_zero_count_high == BYTE_TOP);
  wire        t0_ovf  = t0_tick & t0_step.ovf;
  wire        t1_ovf  = (t1_active & t1_step.ovf) | ((t0_mode == MODE_SPLIT) & th0_ovf);

  wire wr_ctl = reg_write & (reg_addr == ADDR_CONTROL);
  wire wr_mod = reg_write & (reg_addr == ADDR_MODE);
  wire wr_tl0 = reg_write & (reg_addr == ADDR_T0_LOW);
  wire wr_tl1 = reg_write & (reg_addr == ADDR_T1_LOW);
  wire wr_th0 = reg_write & (reg_addr == ADDR_T0_HIGH);
  wire wr_th1 = reg_write & (reg_addr == ADDR_T1_HIGH);

  // Flag next values: hardware set beats software or vector clear
  wire ctl_src_t1f = wr_ctl ? reg_wdata[BIT_T1_FLAG] : timer_irq_control[BIT_T1_FLAG];
  wire ctl_src_t0f = wr_ctl ? reg_wdata[BIT_T0_FLAG] : timer_irq_control[BIT_T0_FLAG];
  wire ctl_src_x1f = wr_ctl ? reg_wdata[BIT_X1_FLAG] : timer_irq_control[BIT_X1_FLAG];
  wire ctl_src_x0f = wr_ctl ? reg_wdata[BIT_X0_FLAG] : timer_irq_control[BIT_X0_FLAG];
  wire x0_type = timer_irq_control[BIT_X0_TYPE];
  wire x1_type = timer_irq_control[BIT_X1_TYPE];
  wire x0_set  = x0_type & fall[0];
  wire x1_set  = x1_type & fall[1];
  wire next_t1_flag = t1_ovf | (ctl_src_t1f & ~ack_timer_one);
  wire next_t0_flag = t0_ovf | (ctl_src_t0f & ~ack_timer_zero);
  wire next_x1_flag = x1_set | (ctl_src_x1f & ~ack_ext_one);
  wire next_x0_flag = x0_set | (ctl_src_x0f & ~ack_ext_zero);

  always_ff @(posedge clk) begin
    if (!nrst) begin
      timer_irq_control <= RESET_BYTE;
      timer_mode_config <= RESET_BYTE;
    end else begin
      if (wr_ctl) timer_irq_control <= reg_wdata;
      if (wr_mod) timer_mode_config <= reg_wdata;
      timer_irq_control[BIT_T1_FLAG] <= next_t1_flag;
      timer_irq_control[BIT_T0_FLAG] <= next_t0_flag;
      timer_irq_control[BIT_X1_FLAG] <= next_x1_flag;
      timer_irq_control[BIT_X0_FLAG] <= next_x0_flag;
    end
  end

  // Software writes win over a count in the same cycle
  always_ff @(posedge clk) begin
    if (!nrst) begin
      timer_zero_count_low  <= RESET_BYTE;
      timer_zero_count_high <= RESET_BYTE;
      timer_one_count_low   <= RESET_BYTE;
      timer_one_count_high  <= RESET_BYTE;
    end else begin
      if (wr_tl0)       timer_zero_count_low <= reg_wdata;
      else if (t0_tick) timer_zero_count_low <= t0_step.low;
      if (wr_th0)       timer_zero_count_high <= reg_wdata;
      else if (t0_mode == MODE_SPLIT) begin
        if (th0_tick)   timer_zero_count_high <= timer_zero_count_high + 8'h01;
      end else if (t0_tick) timer_zero_count_high <= t0_step.high;
      if (wr_tl1)         timer_one_count_low <= reg_wdata;
      else if (t1_active) timer_one_count_low <= t1_step.low;
      if (wr_th1)         timer_one_count_high <= reg_wdata;
      else if (t1_active) timer_one_count_high <= t1_step.high;
    end
  end

  wire [7:0] read_mux =
    (reg_addr == ADDR_CONTROL) ? timer_irq_control :
    (reg_addr == ADDR_MODE)    ? timer_mode_config :
    (reg_addr == ADDR_T0_LOW)  ? timer_zero_count_low :
    (reg_addr == ADDR_T1_LOW)  ? timer_one_count_low :
    (reg_addr == ADDR_T0_HIGH) ? timer_zero_count_high :
    (reg_addr == ADDR_T1_HIGH) ? timer_one_count_high : RESET_BYTE;

  // Level mode requests follow the pin low; edge mode shows the flag
  always_ff @(posedge clk) begin
    if (!nrst) begin
      reg_rdata            <= RESET_BYTE;
      ext_irq_zero_request <= 1'b0;
      ext_irq_one_request  <= 1'b0;
    end else begin
      reg_rdata            <= reg_read ? read_mux : RESET_BYTE;
      ext_irq_zero_request <= x0_type ? next_x0_flag : ~ext_irq_zero_pin_level;
      ext_irq_one_request  <= x1_type ? next_x1_flag : ~ext_irq_one_pin_level;
    end
  end

  // Flag set, clear and hold
  // Set beats clear, so each clear check leaves out a same-cycle set
  a_t0_flag_set: assert property (@(posedge clk) disable iff (!nrst)
    t0_ovf |=> timer_irq_control[BIT_T0_FLAG]) else $error("timer zero flag missed");
  a_t1_flag_set: assert property (@(posedge clk) disable iff (!nrst)
    t1_ovf |=> timer_irq_control[BIT_T1_FLAG]) else $error("timer one flag missed");
  a_t0_flag_ack: assert property (@(posedge clk) disable iff (!nrst)
    ack_timer_zero && !t0_ovf |=> !timer_irq_control[BIT_T0_FLAG])
    else $error("timer zero flag not cleared");
  a_t1_flag_ack: assert property (@(posedge clk) disable iff (!nrst)
    ack_timer_one && !t1_ovf |=> !timer_irq_control[BIT_T1_FLAG])
    else $error("timer one flag not cleared");
  a_t0_flag_hold: assert property (@(posedge clk) disable iff (!nrst)
    !t0_ovf && !wr_ctl && !ack_timer_zero |=> $stable(timer_irq_control[BIT_T0_FLAG]))
    else $error("timer zero flag changed on its own");
  a_t1_flag_hold: assert property (@(posedge clk) disable iff (!nrst)
    !t1_ovf && !wr_ctl && !ack_timer_one |=> $stable(timer_irq_control[BIT_T1_FLAG]))
    else $error("timer one flag changed on its own");
  a_x0_flag_ack: assert property (@(posedge clk) disable iff (!nrst)
    ack_ext_zero && !x0_set |=> !timer_irq_control[BIT_X0_FLAG])
    else $error("interrupt zero flag not cleared");
  a_x1_flag_ack: assert property (@(posedge clk) disable iff (!nrst)
    ack_ext_one && !x1_set |=> !timer_irq_control[BIT_X1_FLAG])
    else $error("interrupt one flag not cleared");

  // Run, gate and count source
  a_halt_holds: assert property (@(posedge clk) disable iff (!nrst)
    !t0_run && !wr_tl0 |=> $stable(timer_zero_count_low)) else $error("halted timer moved");
  a_run_counts: assert property (@(posedge clk) disable iff (!nrst)
    t0_run && !t0_gate && !t0_src && half_rate |-> t0_tick) else $error("running timer idle");
  a_gate_blocks: assert property (@(posedge clk) disable iff (!nrst)
    t0_gate && !ext_irq_zero_pin_level |-> !t0_tick) else $error("gated timer ticked");
  a_rate_half: assert property (@(posedge clk) disable iff (!nrst)
    t0_tick && !t0_src |=> !t0_tick) else $error("timer ticked two cycles running");
  a_t1_rate_half: assert property (@(posedge clk) disable iff (!nrst)
    t1_tick && !t1_src |=> !t1_tick) else $error("timer one ticked two cycles running");
  // A count pin held low must not tick again: the edge stage looks one cycle back
  sequence count_pin_low_s;
    !sync_b[2] ##1 !sync_b[2];
  endsequence
  a_fall_once: assert property (@(posedge clk) disable iff (!nrst)
    count_pin_low_s ##0 t0_src |-> !t0_tick) else $error("held count pin ticked");

  // Counting modes
  // In mode 00 only the low five bits move; the upper three are held
  a_prescale_carry: assert property (@(posedge clk) disable iff (!nrst)
    t0_tick && t0_mode == MODE_PRESCALED && !wr_tl0 && !wr_th0 &&
    (timer_zero_count_low & PRESCALE_MASK) == PRESCALE_TOP |=>
    timer_zero_count_high == $past(timer_zero_count_high) + 8'h01 &&
    (timer_zero_count_low & ~PRESCALE_MASK) == ($past(timer_zero_count_low) & ~PRESCALE_MASK))
    else $error("prescaler carry lost");
  a_full_carry: assert property (@(posedge clk) disable iff (!nrst)
    t0_tick && t0_mode == MODE_FULL && timer_zero_count_low == BYTE_TOP &&
    !wr_tl0 && !wr_th0 |=> timer_zero_count_low == RESET_BYTE &&
    timer_zero_count_high == $past(timer_zero_count_high) + 8'h01)
    else $error("full count carry lost");
  a_reload_low: assert property (@(posedge clk) disable iff (!nrst)
    t0_mode == MODE_RELOAD && t0_ovf && !wr_tl0 && !wr_th0 |=>
    timer_zero_count_low == $past(timer_zero_count_high)) else $error("reload failed");
  a_reload_one: assert property (@(posedge clk) disable iff (!nrst)
    t1_active && t1_mode == MODE_RELOAD && timer_one_count_low == BYTE_TOP && !wr_tl1 |=>
    timer_one_count_low == $past(timer_one_count_high)) else $error("timer one reload failed");
  a_t1_mode_stop: assert property (@(posedge clk) disable iff (!nrst)
    t1_mode == MODE_SPLIT && !wr_tl1 && !wr_th1 |=>
    $stable({timer_one_count_high, timer_one_count_low}))
    else $error("timer one counted in stop mode");
  // Split high byte borrows timer one's run bit and overflow flag
  a_split_high: assert property (@(posedge clk) disable iff (!nrst)
    t0_mode == MODE_SPLIT && th0_tick && !wr_th0 |=>
    timer_zero_count_high == $past(timer_zero_count_high) + 8'h01)
    else $error("split high byte stalled");
  a_split_flag: assert property (@(posedge clk) disable iff (!nrst)
    t0_mode == MODE_SPLIT && th0_ovf |=> timer_irq_control[BIT_T1_FLAG])
    else $error("split overflow missed timer one flag");

  // External interrupt pins and read port
  sequence pin_fall_s;
    sync_b[0] ##1 !sync_b[0];
  endsequence
  a_edge_flag: assert property (@(posedge clk) disable iff (!nrst)
    x0_type && !wr_ctl ##0 pin_fall_s |=> timer_irq_control[BIT_X0_FLAG])
    else $error("edge flag missed");
  a_x1_edge_flag: assert property (@(posedge clk) disable iff (!nrst)
    x1_set |=> timer_irq_control[BIT_X1_FLAG]) else $error("interrupt one flag missed");
  a_level_no_flag: assert property (@(posedge clk) disable iff (!nrst)
    !x0_type && !wr_ctl && !timer_irq_control[BIT_X0_FLAG] |=> !timer_irq_control[BIT_X0_FLAG])
    else $error("level mode set edge flag");
  // Level requests track the synchronised pin, one cycle behind
  a_level_request: assert property (@(posedge clk) disable iff (!nrst)
    !x0_type |=> ext_irq_zero_request == !$past(ext_irq_zero_pin_level))
    else $error("level request does not follow pin");
  a_edge_request: assert property (@(posedge clk) disable iff (!nrst)
    x1_type |=> ext_irq_one_request == timer_irq_control[BIT_X1_FLAG])
    else $error("edge request does not follow flag");
  a_rdata_idle: assert property (@(posedge clk) disable iff (!nrst)
    !reg_read |=> reg_rdata == RESET_BYTE) else $error("read data left standing");

endmodule // dual_timer_counter_extint

//--- pin_model.sv
`timescale 1ns/1ps
module pin_model (
  input  wire logic clk,
  output logic      ext_irq_zero_pin,
  output logic      ext_irq_one_pin,
  output logic      count_input_zero_pin,
  output logic      count_input_one_pin
);
  // Pins idle high, as pulled-up inputs would
  initial begin
    ext_irq_zero_pin = 1'b1;
    ext_irq_one_pin = 1'b1;
    count_input_zero_pin = 1'b1;
    count_input_one_pin = 1'b1;
  end
  // Each level is held longer than the three-stage pin pipeline
  task automatic count_pulse(input int n);
    repeat (n) begin
      @(posedge clk);
      count_input_zero_pin <= 1'b0;
      count_input_one_pin <= 1'b0;
      repeat (4) @(posedge clk);
      count_input_zero_pin <= 1'b1;
      count_input_one_pin <= 1'b1;
      repeat (4) @(posedge clk);
    end
  endtask
  task automatic irq_level(input logic zero, input logic one);
    @(posedge clk);
    ext_irq_zero_pin <= zero;
    ext_irq_one_pin <= one;
  endtask
endmodule // pin_model

//--- tb_dual_timer_counter_extint.sv
`timescale 1ns/1ps
module tb_dual_timer_counter_extint
  import timer_pkg::*;
;
  logic       clk;
  logic       nrst;
  logic [7:0] reg_addr;
  logic       reg_write;
  logic [7:0] reg_wdata;
  logic       reg_read;
  logic [7:0] reg_rdata;
  logic [3:0] acks;
  logic [1:0] req;
  logic [3:0] pin;
  logic [7:0] rv;
  logic [7:0] held;
  int         num_errors = 0;
  int         cmp_count = 0;
  int         cycles = 0;
  dual_timer_counter_extint DUT (
    .clk(clk), .nrst(nrst), .reg_addr(reg_addr), .reg_write(reg_write),
    .reg_wdata(reg_wdata), .reg_read(reg_read), .reg_rdata(reg_rdata),
    .ack_timer_zero(acks[0]), .ack_timer_one(acks[1]), .ack_ext_zero(acks[2]),
    .ack_ext_one(acks[3]), .ext_irq_zero_pin(pin[0]), .ext_irq_one_pin(pin[1]),
    .count_input_zero_pin(pin[2]), .count_input_one_pin(pin[3]),
    .ext_irq_zero_request(req[0]), .ext_irq_one_request(req[1]));
  pin_model pm (
    .clk(clk), .ext_irq_zero_pin(pin[0]), .ext_irq_one_pin(pin[1]),
    .count_input_zero_pin(pin[2]), .count_input_one_pin(pin[3]));
  initial begin
    clk = 1'b0;
    forever #4 clk = ~clk;
  end
  task automatic report_and_stop();
    $display("Comparisons %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) $display("RESULT: PASS");
    else $display("RESULT: FAIL");
    $finish;
  endtask
  // Generous ceiling: the whole sequence needs well under a thousand cycles
  always @(posedge clk) begin
    cycles <= cycles + 1;
    if (cycles == 5000) begin
      num_errors++;
      report_and_stop();
    end
  end
  task automatic check(input logic [7:0] seen, input logic [7:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      num_errors++;
      $display("ERROR t=%0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  task automatic idle(input int n);
    repeat (n) @(posedge clk);
    // Step off the edge so outputs read afterwards have settled
    #1;
  endtask
  task automatic wr(input logic [7:0] a, input logic [7:0] d);
    @(posedge clk);
    reg_addr <= a;
    reg_wdata <= d;
    reg_write <= 1'b1;
    @(posedge clk);
    reg_write <= 1'b0;
  endtask
  // Read data is registered, so it is taken just after the following edge
  task automatic rd(input logic [7:0] a);
    @(posedge clk);
    reg_addr <= a;
    reg_read <= 1'b1;
    @(posedge clk);
    reg_read <= 1'b0;
    #1 rv = reg_rdata;
  endtask
  task automatic ack(input int i);
    @(posedge clk);
    acks[i] <= 1'b1;
    @(posedge clk);
    acks <= 4'h0;
  endtask
  task automatic t_reset();
    for (int a = 8'h88; a <= 8'h8E; a++) begin
      rd(8'(a));
      check(rv, RESET_BYTE);
      check({6'h0, req}, 8'h00);
    end
    for (int a = 8'h8A; a <= 8'h8D; a++) begin
      wr(8'(a), 8'(a));
      rd(8'(a));
      check(rv, 8'(a));
    end
    $display("test reset done");
  endtask
  task automatic t_full();
    wr(ADDR_T0_LOW, 8'hFF);
    wr(ADDR_T0_HIGH, 8'hFF);
    wr(ADDR_MODE, 8'h01);
    wr(ADDR_CONTROL, 8'h10);
    idle(6);
    rd(ADDR_CONTROL);
    check(rv, 8'h30);
    rd(ADDR_T0_HIGH);
    check(rv, 8'h00);
    ack(0);
    rd(ADDR_CONTROL);
    check(rv, 8'h10);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_T0_LOW);
    held = rv;
    idle(6);
    rd(ADDR_T0_LOW);
    check(rv, held);
    $display("test full done");
  endtask
  task automatic t_reload();
    wr(ADDR_T1_HIGH, 8'hF0);
    wr(ADDR_T1_LOW, 8'hFF);
    wr(ADDR_MODE, 8'h20);
    wr(ADDR_CONTROL, 8'h40);
    idle(4);
    rd(ADDR_CONTROL);
    check(rv, 8'hC0);
    wr(ADDR_MODE, 8'h30);
    rd(ADDR_T1_LOW);
    held = rv;
    check(rv & 8'hF0, 8'hF0);
    idle(6);
    rd(ADDR_T1_LOW);
    check(rv, held);
    ack(1);
    rd(ADDR_CONTROL);
    check(rv, 8'h40);
    wr(ADDR_CONTROL, 8'h00);
    $display("test reload done");
  endtask
  task automatic t_prescale();
    wr(ADDR_T0_LOW, 8'hFF);
    wr(ADDR_T0_HIGH, 8'h00);
    wr(ADDR_MODE, 8'h00);
    wr(ADDR_CONTROL, 8'h10);
    idle(4);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_T0_HIGH);
    check(rv, 8'h01);
    rd(ADDR_T0_LOW);
    check(rv & 8'hE0, 8'hE0);
    $display("test prescale done");
  endtask
  task automatic t_reload_zero();
    wr(ADDR_T0_HIGH, 8'h80);
    wr(ADDR_T0_LOW, 8'hFF);
    wr(ADDR_MODE, 8'h02);
    wr(ADDR_CONTROL, 8'h10);
    idle(4);
    rd(ADDR_CONTROL);
    check(rv, 8'h30);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_T0_LOW);
    check(rv & 8'hF0, 8'h80);
    rd(ADDR_T0_HIGH);
    check(rv, 8'h80);
    $display("test reload zero done");
  endtask
  task automatic t_counter();
    wr(ADDR_T0_LOW, 8'h00);
    wr(ADDR_T1_LOW, 8'h00);
    wr(ADDR_MODE, 8'h55);
    wr(ADDR_CONTROL, 8'h50);
    pm.count_pulse(3);
    idle(4);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_T0_LOW);
    check(rv, 8'h03);
    rd(ADDR_T1_LOW);
    check(rv, 8'h03);
    $display("test counter done");
  endtask
  task automatic t_gate();
    wr(ADDR_T0_LOW, 8'h00);
    wr(ADDR_MODE, 8'h09);
    pm.irq_level(1'b0, 1'b1);
    idle(3);
    wr(ADDR_CONTROL, 8'h10);
    idle(8);
    rd(ADDR_T0_LOW);
    check(rv, 8'h00);
    pm.irq_level(1'b1, 1'b1);
    idle(8);
    wr(ADDR_CONTROL, 8'h00);
    rd(ADDR_T0_LOW);
    check({7'h0, rv == 8'h00}, 8'h00);
    $display("test gate done");
  endtask
  task automatic t_extirq();
    wr(ADDR_CONTROL, 8'h05);
    pm.irq_level(1'b0, 1'b0);
    idle(5);
    rd(ADDR_CONTROL);
    check(rv, 8'h0F);
    check({6'h0, req}, 8'h03);
    ack(2);
    rd(ADDR_CONTROL);
    check(rv, 8'h0D);
    ack(3);
    rd(ADDR_CONTROL);
    check(rv, 8'h05);
    check({6'h0, req}, 8'h00);
    wr(ADDR_CONTROL, 8'h00);
    idle(3);
    check({6'h0, req}, 8'h03);
    pm.irq_level(1'b1, 1'b1);
    idle(5);
    check({6'h0, req}, 8'h00);
    $display("test extirq done");
  endtask
  task automatic t_split();
    wr(ADDR_T0_HIGH, 8'hFF);
    wr(ADDR_MODE, 8'h03);
    wr(ADDR_CONTROL, 8'h40);
    idle(6);
    rd(ADDR_CONTROL);
    check(rv, 8'hC0);
    wr(ADDR_CONTROL, 8'h00);
    $display("test split done");
  endtask
  initial begin
    nrst = 1'b0;
    reg_addr = 8'h00;
    reg_write = 1'b0;
    reg_wdata = 8'h00;
    reg_read = 1'b0;
    acks = 4'h0;
    repeat (12) @(posedge clk);
    nrst <= 1'b1;
    t_reset();
    t_full();
    t_reload();
    t_prescale();
    t_reload_zero();
    t_counter();
    t_gate();
    t_extirq();
    t_split();
    report_and_stop();
  end
endmodule // tb_dual_timer_counter_extint

//--- timer_pkg.sv
package timer_pkg;
  localparam logic [7:0] ADDR_CONTROL   = 8'h88;
  localparam logic [7:0] ADDR_MODE      = 8'h89;
  localparam logic [7:0] ADDR_T0_LOW    = 8'h8A;
  localparam logic [7:0] ADDR_T1_LOW    = 8'h8B;
  localparam logic [7:0] ADDR_T0_HIGH   = 8'h8C;
  localparam logic [7:0] ADDR_T1_HIGH   = 8'h8D;
  localparam logic [7:0] RESET_BYTE     = 8'h00;
  // Control register bit positions
  localparam int BIT_T1_FLAG  = 7;
  localparam int BIT_T1_RUN   = 6;
  localparam int BIT_T0_FLAG  = 5;
  localparam int BIT_T0_RUN   = 4;
  localparam int BIT_X1_FLAG  = 3;
  localparam int BIT_X1_TYPE  = 2;
  localparam int BIT_X0_FLAG  = 1;
  localparam int BIT_X0_TYPE  = 0;
  // Mode register: timer one in the upper nibble, timer zero in the lower
  localparam int BIT_T1_GATE  = 7;
  localparam int BIT_T1_SRC   = 6;
  localparam int BIT_T1_MODE  = 4;
  localparam int BIT_T0_GATE  = 3;
  localparam int BIT_T0_SRC   = 2;
  localparam int BIT_T0_MODE  = 0;
  localparam logic [1:0] MODE_PRESCALED = 2'h0;
  localparam logic [1:0] MODE_FULL      = 2'h1;
  localparam logic [1:0] MODE_RELOAD    = 2'h2;
  localparam logic [1:0] MODE_SPLIT     = 2'h3;
  localparam logic [7:0] PRESCALE_MASK  = 8'h1F;
  localparam logic [7:0] PRESCALE_TOP   = 8'h1F;
  localparam logic [7:0] BYTE_TOP       = 8'hFF;
endpackage
